// ==== hdl/tcio_top.sv ====
// Channel 4 pin I/O control: compare output and input capture for registers A and C
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Compare mode 0x01: drive initial level from bit 2, go low on match.
// - Compare mode 0x10: drive initial level from bit 2, go high on match.
// - Compare mode 0x11: drive initial level from bit 2, toggle on every match.
// - Capture mode 1x00: capture counter on rising pin edge.
// - Capture mode 1x01: capture counter on falling pin edge.
// - Capture mode 1x1x: capture counter on both pin edges.
// - After reset each compare pin is driven low until its control is written.
// - Buffer mode for A disables capture and compare for register C.
module tcio_top #(
	parameter int ADDR_W = 8
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [tcio_pkg::GR_W-1:0] i_counter,
	input wire logic i_ch4_pin_a,
	output logic o_ch4_pin_a,
	output logic o_ch4_pin_a_oe,
	input wire logic i_ch4_pin_c,
	output logic o_ch4_pin_c,
	output logic o_ch4_pin_c_oe,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [ADDR_W-1:0] i_awaddr,
	input wire logic [2:0] i_awprot,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [ADDR_W-1:0] i_araddr,
	input wire logic [2:0] i_arprot,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp
);

	if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
		$error("tcio_top: ADDR_W must lie in 5..8");
	end

	// Read word must hold a whole general register; fields sit in byte lane 0
	if (tcio_pkg::GR_W > 32 || tcio_pkg::MODE_BUFFER_A_BIT > 7
		|| tcio_pkg::IO_FIELD_LSB + tcio_pkg::IO_FIELD_W > 8) begin : g_bad_pkg
		$error("tcio_top: package widths do not fit the bus word");
	end

	tcio_pkg::tcio_state_t st_ff;
	tcio_pkg::tcio_state_t nxt_st;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic tcio_pkg::tcio_reg_t decode(input logic [7:0] addr);
		case (addr)
			tcio_pkg::OFS_IO_CONTROL_HIGH: decode = tcio_pkg::TCIO_REG_HIGH;
			tcio_pkg::OFS_IO_CONTROL_LOW: decode = tcio_pkg::TCIO_REG_LOW;
			tcio_pkg::OFS_MODE: decode = tcio_pkg::TCIO_REG_MODE;
			tcio_pkg::OFS_GENERAL_A: decode = tcio_pkg::TCIO_REG_GA;
			tcio_pkg::OFS_GENERAL_C: decode = tcio_pkg::TCIO_REG_GC;
			tcio_pkg::OFS_STATUS: decode = tcio_pkg::TCIO_REG_STATUS;
			default: decode = tcio_pkg::TCIO_REG_NONE;
		endcase
	endfunction

	// I/O field as it sits in a written word
	function automatic logic [3:0] io_field(input logic [31:0] word);
		io_field = word[tcio_pkg::IO_FIELD_LSB +: tcio_pkg::IO_FIELD_W];
	endfunction

	// New I/O field; an output mode other than retain loads its initial level at once
	function automatic tcio_pkg::tcio_chan_t write_mode(
		input tcio_pkg::tcio_chan_t c,
		input logic [3:0] field
	);
		tcio_pkg::tcio_chan_t r;
		r = c;
		r.mode = field;
		// Retain leaves whatever level the pin already shows
		if (!field[tcio_pkg::IO_CAPTURE_BIT] && field[1:0] != tcio_pkg::ACT_RETAIN) begin
			r.level = field[tcio_pkg::IO_LEVEL_BIT];
		end
		write_mode = r;
	endfunction

	// One cycle of compare or capture work for one channel
	function automatic tcio_pkg::tcio_chan_t step(
		input tcio_pkg::tcio_chan_t c,
		input logic [tcio_pkg::GR_W-1:0] cnt,
		input logic [tcio_pkg::GR_W-1:0] gr,
		input logic pin_in,
		input logic enabled
	);
		tcio_pkg::tcio_chan_t r;
		logic match;
		logic rise;
		logic fall;
		r = c;
		match = (cnt == gr);
		// Pin taken as synchronous; edges come from two successive samples
		rise = pin_in && !c.prev_in;
		fall = !pin_in && c.prev_in;
		r.capt = 1'b0;
		if (!c.mode[tcio_pkg::IO_CAPTURE_BIT]) begin
			r.oe = 1'b1;
			// Edge of match only, so a stalled counter acts once
			if (enabled && match && !c.prev_match) begin
				case (c.mode[1:0])
					tcio_pkg::ACT_LOW: r.level = 1'b0;
					tcio_pkg::ACT_HIGH: r.level = 1'b1;
					tcio_pkg::ACT_TOGGLE: r.level = !c.level;
					default: r.level = c.level;
				endcase
			end
		end else begin
			r.oe = 1'b0;
			if (enabled) begin
				if (c.mode[1]) begin
					r.capt = rise || fall;
				end else if (c.mode[0]) begin
					r.capt = fall;
				end else begin
					r.capt = rise;
				end
			end
		end
		r.prev_in = pin_in;
		r.prev_match = match;
		step = r;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		tcio_pkg::tcio_reg_t wsel;
		tcio_pkg::tcio_reg_t rsel;
		logic [7:0] raddr;
		logic [31:0] rd;
		logic [1:0] pins;
		logic [1:0] c_en;
		wsel = tcio_pkg::TCIO_REG_NONE;
		rsel = tcio_pkg::TCIO_REG_NONE;
		raddr = 8'h00;
		rd = 32'h0000_0000;
		pins = {i_ch4_pin_c, i_ch4_pin_a};
		c_en = {!st_ff.buffer_mode_a_enable, 1'b1};
		nxt_st = st_ff;
		if (st_ff.bvalid && i_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		if (st_ff.rvalid && i_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (st_ff.awready && i_awvalid) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = 8'(i_awaddr);
		end
		if (st_ff.wready && i_wvalid) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = i_wdata;
			nxt_st.wstrb = i_wstrb;
		end
		for (int i = 0; i < 2; i++) begin
			nxt_st.ch[i].capt = 1'b0;
		end

		// Register write, once address and data are both held
		if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
			wsel = decode(st_ff.awaddr);
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = tcio_pkg::RESP_OKAY;
			case (wsel)
				tcio_pkg::TCIO_REG_HIGH: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.ch[0] = write_mode(st_ff.ch[0], io_field(st_ff.wdata));
					end
				end
				tcio_pkg::TCIO_REG_LOW: begin
					// Buffered C keeps its field for readback but never loads a level
					if (st_ff.wstrb[0] && st_ff.buffer_mode_a_enable) begin
						nxt_st.ch[1].mode = io_field(st_ff.wdata);
					end else if (st_ff.wstrb[0]) begin
						nxt_st.ch[1] = write_mode(st_ff.ch[1], io_field(st_ff.wdata));
					end
				end
				tcio_pkg::TCIO_REG_MODE: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.buffer_mode_a_enable = st_ff.wdata[tcio_pkg::MODE_BUFFER_A_BIT];
					end
				end
				tcio_pkg::TCIO_REG_GA, tcio_pkg::TCIO_REG_GC: begin
					for (int b = 0; b < 2; b++) begin
						if (st_ff.wstrb[b]) begin
							nxt_st.gr[wsel == tcio_pkg::TCIO_REG_GC][b*8 +: 8] =
								st_ff.wdata[b*8 +: 8];
						end
					end
				end
				tcio_pkg::TCIO_REG_STATUS: begin
					// Write one to clear; a capture in this cycle sets it again below
					if (st_ff.wstrb[0]) begin
						if (st_ff.wdata[tcio_pkg::STAT_CAPT_A_BIT]) begin
							nxt_st.ch[0].capt_flag = 1'b0;
						end
						if (st_ff.wdata[tcio_pkg::STAT_CAPT_C_BIT]) begin
							nxt_st.ch[1].capt_flag = 1'b0;
						end
					end
				end
				default: nxt_st.bresp = tcio_pkg::RESP_SLVERR;
			endcase
		end

		// Compare and capture
		// A capture beats a same-cycle software write to the general register
		for (int i = 0; i < 2; i++) begin
			nxt_st.ch[i] = step(nxt_st.ch[i], i_counter, st_ff.gr[i], pins[i], c_en[i]);
			if (nxt_st.ch[i].capt) begin
				nxt_st.gr[i] = i_counter;
				nxt_st.ch[i].capt_flag = 1'b1;
			end
		end

		// Register read
		if (st_ff.arready && i_arvalid) begin
			raddr = 8'(i_araddr);
			rsel = decode(raddr);
			// Reserved bits read as zero
			case (rsel)
				tcio_pkg::TCIO_REG_HIGH: rd[3:0] = st_ff.ch[0].mode;
				tcio_pkg::TCIO_REG_LOW: rd[3:0] = st_ff.ch[1].mode;
				tcio_pkg::TCIO_REG_MODE: rd[tcio_pkg::MODE_BUFFER_A_BIT] = st_ff.buffer_mode_a_enable;
				tcio_pkg::TCIO_REG_GA: rd[tcio_pkg::GR_W-1:0] = st_ff.gr[0];
				tcio_pkg::TCIO_REG_GC: rd[tcio_pkg::GR_W-1:0] = st_ff.gr[1];
				tcio_pkg::TCIO_REG_STATUS: begin
					rd[tcio_pkg::STAT_PIN_A_BIT] = st_ff.ch[0].level;
					rd[tcio_pkg::STAT_PIN_C_BIT] = st_ff.ch[1].level;
					rd[tcio_pkg::STAT_CAPT_A_BIT] = st_ff.ch[0].capt_flag;
					rd[tcio_pkg::STAT_CAPT_C_BIT] = st_ff.ch[1].capt_flag;
				end
				default: rd = 32'h0000_0000;
			endcase
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd;
			nxt_st.rresp = (rsel == tcio_pkg::TCIO_REG_NONE) ? tcio_pkg::RESP_SLVERR :
				tcio_pkg::RESP_OKAY;
		end

		// One transfer per channel at a time
		nxt_st.awready = !nxt_st.aw_got;
		nxt_st.wready = !nxt_st.w_got;
		nxt_st.arready = !nxt_st.rvalid;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			// Pins come out of reset driven low in retain mode
			st_ff <= '0;
			for (int i = 0; i < 2; i++) begin
				st_ff.ch[i].mode <= tcio_pkg::RST_IO_FIELD;
				st_ff.ch[i].level <= tcio_pkg::RST_PIN_LEVEL;
				st_ff.ch[i].oe <= 1'b1;
				st_ff.gr[i] <= tcio_pkg::RST_GENERAL;
			end
			st_ff.buffer_mode_a_enable <= tcio_pkg::RST_BUFFER_A;
			st_ff.awready <= 1'b1;
			st_ff.wready <= 1'b1;
			st_ff.arready <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs, straight from the state register
	// ------------------------------------------------------------
	assign o_ch4_pin_a = st_ff.ch[0].level;
	assign o_ch4_pin_a_oe = st_ff.ch[0].oe;
	assign o_ch4_pin_c = st_ff.ch[1].level;
	assign o_ch4_pin_c_oe = st_ff.ch[1].oe;
	assign o_awready = st_ff.awready;
	assign o_wready = st_ff.wready;
	assign o_bvalid = st_ff.bvalid;
	assign o_bresp = st_ff.bresp;
	assign o_arready = st_ff.arready;
	assign o_rvalid = st_ff.rvalid;
	assign o_rdata = st_ff.rdata;
	assign o_rresp = st_ff.rresp;

endmodule

// ==== hdl/tcio_pkg.sv ====
// Constants and carrier types for the channel 4 pin I/O control block
package tcio_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_IO_CONTROL_HIGH = 8'h00;
	localparam logic [7:0] OFS_IO_CONTROL_LOW = 8'h04;
	localparam logic [7:0] OFS_MODE = 8'h08;
	localparam logic [7:0] OFS_GENERAL_A = 8'h0C;
	localparam logic [7:0] OFS_GENERAL_C = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int IO_FIELD_LSB = 0;
	localparam int IO_FIELD_W = 4;
	localparam int IO_CAPTURE_BIT = 3;
	localparam int IO_LEVEL_BIT = 2;
	localparam int MODE_BUFFER_A_BIT = 4;
	localparam int STAT_PIN_A_BIT = 0;
	localparam int STAT_PIN_C_BIT = 1;
	localparam int STAT_CAPT_A_BIT = 2;
	localparam int STAT_CAPT_C_BIT = 3;
	localparam int GR_W = 16;

	// ------------------------------------------------------------
	// Reset values and bus answers
	// ------------------------------------------------------------
	localparam logic [3:0] RST_IO_FIELD = 4'h0;
	localparam logic RST_PIN_LEVEL = 1'b0;
	localparam logic [GR_W-1:0] RST_GENERAL = 16'hFFFF;
	localparam logic RST_BUFFER_A = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Output actions on compare match
	localparam logic [1:0] ACT_RETAIN = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;

	typedef enum {
		TCIO_REG_HIGH,
		TCIO_REG_LOW,
		TCIO_REG_MODE,
		TCIO_REG_GA,
		TCIO_REG_GC,
		TCIO_REG_STATUS,
		TCIO_REG_NONE
	} tcio_reg_t;

	// Per-channel pin state
	typedef struct packed {
		logic [3:0] mode;
		logic level;
		logic oe;
		logic prev_in;
		logic prev_match;
		logic capt_flag;
		logic capt;
	} tcio_chan_t;

	// Whole block state
	typedef struct packed {
		tcio_chan_t [1:0] ch;
		logic [1:0][GR_W-1:0] gr;
		logic buffer_mode_a_enable;
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tcio_state_t;

endpackage

// ==== bench/tcio_pin_model.sv ====
// Outside world of the channel 4 pins: a source that drives a pin when the block lets go
`timescale 1ns/1ps
module tcio_pin_model (
	input wire logic i_drive,
	input wire logic i_out,
	input wire logic i_oe,
	output logic o_pin
);
	// Block level while it drives, else the outside source
	assign o_pin = i_oe ? i_out : i_drive;
endmodule

// ==== bench/tcio_chk_sva.sv ====
// Port-level assertions for the channel 4 pin I/O control block
`timescale 1ns/1ps
module tcio_chk (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [tcio_pkg::GR_W-1:0] i_counter,
	input wire logic o_ch4_pin_a,
	input wire logic o_ch4_pin_a_oe,
	input wire logic o_ch4_pin_c,
	input wire logic o_ch4_pin_c_oe,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic i_rready
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	rst_pin_a_a: assert property ($past(i_reset) |-> !o_ch4_pin_a && o_ch4_pin_a_oe)
		else $error("pin A not driven low after reset");
	rst_pin_c_a: assert property ($past(i_reset) |-> !o_ch4_pin_c && o_ch4_pin_c_oe)
		else $error("pin C not driven low after reset");
	rst_bus_a: assert property ($past(i_reset) |-> !o_bvalid && !o_rvalid && o_awready && o_arready)
		else $error("bus not idle after reset");
	wr_resp_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
		else $error("write response late");
	b_done_a: assert property (o_bvalid && i_bready |=> !o_bvalid)
		else $error("write response not retired");
	rd_resp_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
		else $error("read response late");
	r_done_a: assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready)
		else $error("read response not retired");
	oe_cause_a: assert property (!$past(i_reset) && $changed(o_ch4_pin_a_oe) |-> $rose(o_bvalid))
		else $error("pin A enable changed without a write");
	// Counter steady for four samples and no write means no compare event can be pending
	pin_hold_a: assert property (o_ch4_pin_a_oe && !$past(i_reset) && !o_bvalid
		&& !$past(o_bvalid) && !$past(o_bvalid, 2) && $stable(i_counter)
		&& $past(i_counter) == $past(i_counter, 2) && $past(i_counter, 2) == $past(i_counter, 3)
		|-> $stable(o_ch4_pin_a)) else $error("pin A moved without cause");
	wr_c: cover property (o_bvalid && i_bready);
	rd_c: cover property (o_rvalid && i_rready);
	pin_c: cover property ($rose(o_ch4_pin_a));
endmodule
bind tcio_top tcio_chk i_chk (.i_clock(i_clock), .i_reset(i_reset), .i_counter(i_counter),
	.o_ch4_pin_a(o_ch4_pin_a), .o_ch4_pin_a_oe(o_ch4_pin_a_oe), .o_ch4_pin_c(o_ch4_pin_c),
	.o_ch4_pin_c_oe(o_ch4_pin_c_oe), .i_awvalid(i_awvalid), .o_awready(o_awready),
	.i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
	.i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready));

// ==== bench/tb.sv ====
// Self-checking bench for the channel 4 pin I/O control block
`timescale 1ns/1ps
module tb;
	logic clk, rst, awv, wv, arv, brdy, rrdy, drv_a;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdat;
	logic [3:0] ws;
	logic [1:0] rsp, wrsp;
	logic [15:0] cnt;
	wire pa, pc, ya, yc, ea, ec, awr, wrd, bv, arr, rv;
	wire [1:0] br, rr;
	wire [31:0] rdd;
	int n_mismatch, checks_done, cyc;
	// Compare rows: field, initial level, level after match
	logic [5:0] cmp [8] = '{6'h00, 6'h16, 6'h09, 6'h13, 6'h04, 6'h1B, 6'h0D, 6'h1E};
	// Capture rows: field, captures on rise, captures on fall
	logic [5:0] cap [3] = '{6'h22, 6'h35, 6'h3B};
	tcio_pin_model i_pa (.i_drive(drv_a), .i_out(ya), .i_oe(ea), .o_pin(pa));
	tcio_pin_model i_pc (.i_drive(1'b0), .i_out(yc), .i_oe(ec), .o_pin(pc));
	tcio_top i_dut (.i_clock(clk), .i_reset(rst), .i_counter(cnt), .i_ch4_pin_a(pa),
		.o_ch4_pin_a(ya), .o_ch4_pin_a_oe(ea), .i_ch4_pin_c(pc), .o_ch4_pin_c(yc),
		.o_ch4_pin_c_oe(ec), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
		.i_awprot(3'h0), .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd), .i_wstrb(ws),
		.o_bvalid(bv), .i_bready(brdy), .o_bresp(br), .i_arvalid(arv), .o_arready(arr),
		.i_araddr(ara), .i_arprot(3'h0), .o_rvalid(rv), .i_rready(rrdy), .o_rdata(rdd),
		.o_rresp(rr));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
		end while (!bv);
		wrsp = br;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		ara <= a;
		arv <= 1'b1;
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		do @(posedge clk); while (!rv);
		d = rdd;
		r = rr;
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			finish_test();
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{awv, wv, arv, drv_a, awa, ara, wd, cnt} = '0;
		{brdy, rrdy, rst, ws} = {3'h7, 4'hF};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("pin A after reset", 32'({ea, ya}), 32'h2);
		chk("pin C after reset", 32'({ec, yc}), 32'h2);
		rd(tcio_pkg::OFS_IO_CONTROL_LOW, rdat, rsp);
		chk("io low reset", rdat, 32'h0);
		chk("read resp", 32'(rsp), 32'(tcio_pkg::RESP_OKAY));
		rd(tcio_pkg::OFS_GENERAL_A, rdat, rsp);
		chk("general A reset", rdat, 32'(tcio_pkg::RST_GENERAL));
		rd(tcio_pkg::OFS_GENERAL_C, rdat, rsp);
		chk("general C reset", rdat, 32'(tcio_pkg::RST_GENERAL));
		rd(8'h18, rdat, rsp);
		chk("unmapped data", rdat, 32'h0);
		chk("unmapped resp", 32'(rsp), 32'(tcio_pkg::RESP_SLVERR));
		wr(8'h18, 32'hFFFF_FFFF);
		chk("unmapped write resp", 32'(wrsp), 32'(tcio_pkg::RESP_SLVERR));
		wr(tcio_pkg::OFS_GENERAL_A, 32'h40);
		chk("write resp", 32'(wrsp), 32'(tcio_pkg::RESP_OKAY));
		for (int i = 0; i < 8; i++) begin
			cnt <= 16'h0;
			wr(tcio_pkg::OFS_IO_CONTROL_HIGH, 32'(cmp[i][5:2]));
			chk("pin A initial", 32'({ea, ya}), 32'({1'b1, cmp[i][1]}));
			cnt <= 16'h40;
			repeat (4) @(posedge clk);
			chk("pin A match", ya, cmp[i][0]);
		end
		cnt <= 16'h0;
		for (int i = 0; i < 3; i++) begin
			wr(tcio_pkg::OFS_IO_CONTROL_HIGH, 32'(cap[i][5:2]));
			wr(tcio_pkg::OFS_GENERAL_A, 32'h0);
			chk("capture oe", ea, 32'h0);
			cnt <= 16'h111;
			drv_a <= 1'b1;
			repeat (4) @(posedge clk);
			rd(tcio_pkg::OFS_GENERAL_A, rdat, rsp);
			chk("rise capture", rdat, cap[i][1] ? 32'h111 : 32'h0);
			cnt <= 16'h222;
			drv_a <= 1'b0;
			repeat (4) @(posedge clk);
			rd(tcio_pkg::OFS_GENERAL_A, rdat, rsp);
			chk("fall capture", rdat, cap[i][0] ? 32'h222 : (cap[i][1] ? 32'h111 : 32'h0));
		end
		rd(tcio_pkg::OFS_STATUS, rdat, rsp);
		chk("status after capture", rdat, 32'h1 << tcio_pkg::STAT_CAPT_A_BIT);
		wr(tcio_pkg::OFS_STATUS, 32'h1 << tcio_pkg::STAT_CAPT_A_BIT);
		rd(tcio_pkg::OFS_STATUS, rdat, rsp);
		chk("status cleared", rdat, 32'h0);
		wr(tcio_pkg::OFS_MODE, 32'h10);
		wr(tcio_pkg::OFS_IO_CONTROL_LOW, 32'h6);
		cnt <= 16'hFFFF;
		repeat (4) @(posedge clk);
		chk("pin C buffered", 32'({ec, yc}), 32'h2);
		cnt <= 16'h0;
		wr(tcio_pkg::OFS_MODE, 32'h0);
		wr(tcio_pkg::OFS_IO_CONTROL_LOW, 32'h6);
		chk("pin C initial", yc, 32'h1);
		wr(tcio_pkg::OFS_IO_CONTROL_HIGH, 32'hFFFFFFFF);
		rd(tcio_pkg::OFS_IO_CONTROL_HIGH, rdat, rsp);
		chk("io high readback", rdat, 32'hF);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("pins after mid-run reset", 32'({ec, yc, ea, ya}), 32'hA);
		rd(tcio_pkg::OFS_IO_CONTROL_LOW, rdat, rsp);
		chk("io low after reset", rdat, 32'h0);
		finish_test();
	end
endmodule
